/* dsgate_pkg.sv */
package dsgate_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] RUN_GATE_OFS = 12'h100;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
    localparam logic [11:0] DEEP_GATE_OFS = 12'h120;
    localparam logic [11:0] CLK_CFG_OFS = 12'h060;
    localparam logic [11:0] MODE_OFS = 12'h130;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h140;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h144;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int ADC_BIT = 16;
    localparam int RATE_HI = 9;
    localparam int RATE_LO = 8;
    localparam int HIB_BIT = 6;
    localparam int WDT_BIT = 3;
    localparam int ACG_BIT = 27;
    localparam logic [31:0] GATE_WMASK = 32'h0001_0348;
    localparam logic [31:0] GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] RUN_RESET = 32'h0000_0040;
    localparam logic [31:0] CFG_WMASK = 32'h0800_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Sample rate codes
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_500K = 2'h2;

    // Interrupt status: fault on converter, watchdog, hibernate
    localparam int IRQ_W = 3;
    localparam int IRQ_ADC = 0;
    localparam int IRQ_WDT = 1;
    localparam int IRQ_HIB = 2;

    // Power modes
    typedef enum logic [2:0] {
        MODE_RUN = 3'h1,
        MODE_SLEEP = 3'h2,
        MODE_DEEP = 3'h4
    } power_mode_e;

    localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_CODE_DEEP = 2'h2;

endpackage

/* gate_select.sv */
`timescale 1ns/1ps
`default_nettype none
module gate_select
    import dsgate_pkg::*;
(
    input wire logic [31:0] run_gate_i,   // Run mode enables
    input wire logic [31:0] sleep_gate_i, // Sleep mode enables
    input wire logic [31:0] deep_gate_i,  // Deep-sleep enables
    input wire logic auto_gate_i,         // Automatic gating on
    input wire power_mode_e mode_i,       // Current power mode
    output logic [31:0] active_o          // Selected enables
);

    always_comb begin
        active_o = run_gate_i;
        if (auto_gate_i) begin
            case (mode_i)
                MODE_SLEEP: active_o = sleep_gate_i;
                MODE_DEEP: active_o = deep_gate_i;
                default: active_o = run_gate_i;
            endcase
        end
    end

endmodule // gate_select
`default_nettype wire

/* deep_sleep_clock_gating.sv */
// Notes on behaviour
// - One clocks the unit; zero leaves it unclocked and disabled.
// - Access to a unit whose clock is off is answered with a bus fault.
// - Deep-sleep gating register resets to 0x00000040.
// - Bit 16 gates the converter clock, access faults when gated.
// - Bits 9:8 pick converter rate: 2=500K, 1=250K, 0=125K.
// - Bit 6 gates the hibernation module clock.
// - Bit 3 gates the watchdog clock, access faults when gated.
// - Reserved bits read zero and ignore writes.
// - Sleep and deep-sleep registers act only with automatic gating set.
// - Sleep register at 0x110, same layout and reset, used in sleep.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_clock_gating
    import dsgate_pkg::*;
#(
    parameter int REG_W = 32,             // Register width
    parameter int N_UNITS = 3             // Gated units with fault status
)
(
    input wire logic mclk_i,              // System clock
    input wire logic rst_b_i,             // Async reset, active low
    input wire logic [11:0] addr_i,       // Register byte address
    input wire logic [31:0] wdata_i,      // Write data
    input wire logic wr_i,                // Write strobe
    input wire logic rd_i,                // Read strobe
    output logic [31:0] rdata_o,          // Read data, cycle after read
    input wire logic per_sel_adc_i,       // Converter access request
    input wire logic per_sel_wdt_i,       // Watchdog access request
    input wire logic per_sel_hib_i,       // Hibernate access request
    output logic per_fault_o,             // Bus fault for gated access
    output logic adc_clk_en_o,            // Converter clock enable
    output logic hib_clk_en_o,            // Hibernate clock enable
    output logic wdt_clk_en_o,            // Watchdog clock enable
    output logic [1:0] converter_sample_rate_o, // Active rate code
    output logic irq_o                    // Interrupt, level
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] run_gate_reg, next_run_gate_reg;
    logic [31:0] sleep_gate_reg, next_sleep_gate_reg;
    logic [31:0] deep_gate_reg, next_deep_gate_reg;
    logic [31:0] run_clock_config, next_run_clock_config;
    power_mode_e mode, next_mode;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [31:0] rdata, next_rdata;
    logic [31:0] active;
    logic auto_gating_select;
    logic [IRQ_W-1:0] fault_evt;

    assign auto_gating_select = run_clock_config[ACG_BIT];

    gate_select u_sel (
        .run_gate_i(run_gate_reg),
        .sleep_gate_i(sleep_gate_reg),
        .deep_gate_i(deep_gate_reg),
        .auto_gate_i(auto_gating_select),
        .mode_i(mode),
        .active_o(active)
    );

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (REG_W != 32) begin : g_bad_width
        $error("register width must be 32");
    end
    if (N_UNITS != IRQ_W) begin : g_bad_units
        $error("unit count must match the status width");
    end

    // ----------------------------------------------------------------
    // Register writes and reads
    // ----------------------------------------------------------------
    always_comb begin
        next_run_gate_reg = run_gate_reg;
        next_sleep_gate_reg = sleep_gate_reg;
        next_deep_gate_reg = deep_gate_reg;
        next_run_clock_config = run_clock_config;
        next_mode = mode;
        next_irq_mask = irq_mask;
        next_rdata = 32'h0000_0000;
        if (wr_i) begin
            case (addr_i)
                RUN_GATE_OFS: next_run_gate_reg = wdata_i & GATE_WMASK;
                SLEEP_GATE_OFS: next_sleep_gate_reg = wdata_i & GATE_WMASK;
                DEEP_GATE_OFS: next_deep_gate_reg = wdata_i & GATE_WMASK;
                CLK_CFG_OFS: next_run_clock_config = wdata_i & CFG_WMASK;
                MODE_OFS: begin
                    case (wdata_i[1:0])
                        MODE_CODE_SLEEP: next_mode = MODE_SLEEP;
                        MODE_CODE_DEEP: next_mode = MODE_DEEP;
                        default: next_mode = MODE_RUN;
                    endcase
                end
                IRQ_MASK_OFS: next_irq_mask = wdata_i[IRQ_W-1:0];
                default: next_mode = mode;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                RUN_GATE_OFS: next_rdata = run_gate_reg;
                SLEEP_GATE_OFS: next_rdata = sleep_gate_reg;
                DEEP_GATE_OFS: next_rdata = deep_gate_reg;
                CLK_CFG_OFS: next_rdata = run_clock_config;
                MODE_OFS: begin
                    case (mode)
                        MODE_SLEEP: next_rdata = {30'h0, MODE_CODE_SLEEP};
                        MODE_DEEP: next_rdata = {30'h0, MODE_CODE_DEEP};
                        default: next_rdata = 32'h0000_0000;
                    endcase
                end
                IRQ_STAT_OFS: next_rdata = {{(32-IRQ_W){1'b0}}, irq_stat};
                IRQ_MASK_OFS: next_rdata = {{(32-IRQ_W){1'b0}}, irq_mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Gated-unit fault events and sticky status
    // ----------------------------------------------------------------
    logic next_fault;
    logic next_adc_en, next_hib_en, next_wdt_en;
    logic [1:0] next_rate;
    logic next_irq;

    always_comb begin
        fault_evt[IRQ_ADC] = per_sel_adc_i & ~active[ADC_BIT];
        fault_evt[IRQ_WDT] = per_sel_wdt_i & ~active[WDT_BIT];
        fault_evt[IRQ_HIB] = per_sel_hib_i & ~active[HIB_BIT];
        next_fault = |fault_evt;
        next_irq_stat = irq_stat;
        if (wr_i && addr_i == IRQ_STAT_OFS) begin
            next_irq_stat = irq_stat & ~wdata_i[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | fault_evt;
        next_irq = |(next_irq_stat & next_irq_mask);
        next_adc_en = active[ADC_BIT];
        next_hib_en = active[HIB_BIT];
        next_wdt_en = active[WDT_BIT];
        next_rate = active[RATE_HI:RATE_LO];
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_gate_reg <= RUN_RESET;
            sleep_gate_reg <= GATE_RESET;
            deep_gate_reg <= GATE_RESET;
            run_clock_config <= CFG_RESET;
            mode <= MODE_RUN;
            irq_stat <= '0;
            irq_mask <= '0;
            rdata <= 32'h0000_0000;
            per_fault_o <= 1'b0;
            adc_clk_en_o <= 1'b0;
            hib_clk_en_o <= 1'b0;
            wdt_clk_en_o <= 1'b0;
            converter_sample_rate_o <= RATE_125K;
            irq_o <= 1'b0;
        end else begin
            run_gate_reg <= next_run_gate_reg;
            sleep_gate_reg <= next_sleep_gate_reg;
            deep_gate_reg <= next_deep_gate_reg;
            run_clock_config <= next_run_clock_config;
            mode <= next_mode;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata <= next_rdata;
            per_fault_o <= next_fault;
            adc_clk_en_o <= next_adc_en;
            hib_clk_en_o <= next_hib_en;
            wdt_clk_en_o <= next_wdt_en;
            converter_sample_rate_o <= next_rate;
            irq_o <= next_irq;
        end
    end

    assign rdata_o = rdata;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    chk_adc_fault: assert property (
        per_sel_adc_i && !active[ADC_BIT] |=> per_fault_o)
        else $error("gated converter access did not fault");
    chk_wdt_fault: assert property (
        per_sel_wdt_i && !active[WDT_BIT] |=> per_fault_o)
        else $error("gated watchdog access did not fault");
    chk_no_fault: assert property (
        !(per_sel_adc_i && !active[ADC_BIT]) && !(per_sel_wdt_i && !active[WDT_BIT])
        && !(per_sel_hib_i && !active[HIB_BIT]) |=> !per_fault_o)
        else $error("fault without gated access");
    chk_deep_select: assert property (
        auto_gating_select && mode == MODE_DEEP |=> adc_clk_en_o == $past(deep_gate_reg[ADC_BIT]))
        else $error("deep-sleep enables not applied");
    chk_run_select: assert property (
        !auto_gating_select |=> hib_clk_en_o == $past(run_gate_reg[HIB_BIT]))
        else $error("run enables not applied");
    chk_sleep_select: assert property (
        auto_gating_select && mode == MODE_SLEEP
        |=> wdt_clk_en_o == $past(sleep_gate_reg[WDT_BIT]))
        else $error("sleep enables not applied");
    chk_reserved_zero: assert property (
        (deep_gate_reg & ~GATE_WMASK) == 32'h0000_0000)
        else $error("reserved bit set");
    chk_deep_write: assert property (
        wr_i && addr_i == DEEP_GATE_OFS |=> deep_gate_reg == ($past(wdata_i) & GATE_WMASK))
        else $error("deep gating write lost");
    chk_read_data: assert property (
        rd_i && addr_i == DEEP_GATE_OFS |=> rdata_o == $past(deep_gate_reg))
        else $error("deep gating read wrong");
    chk_rate_deep: assert property (
        auto_gating_select && mode == MODE_DEEP
        |=> converter_sample_rate_o == $past(deep_gate_reg[RATE_HI:RATE_LO]))
        else $error("rate field not applied");
    chk_irq_sticky: assert property (
        |fault_evt |=> (irq_stat & $past(fault_evt)) == $past(fault_evt))
        else $error("fault status lost");

    // ----------------------------------------------------------------
    // Fault, enable, status and register checks
    // ----------------------------------------------------------------
    chk_hib_fault: assert property (
        per_sel_hib_i && !active[HIB_BIT] |=> per_fault_o)
        else $error("gated hibernate access did not fault");
    chk_adc_enable: assert property (
        1'b1 |=> adc_clk_en_o == $past(active[ADC_BIT]))
        else $error("converter enable does not follow selection");
    chk_wdt_enable: assert property (
        1'b1 |=> wdt_clk_en_o == $past(active[WDT_BIT]))
        else $error("watchdog enable does not follow selection");
    chk_hib_enable: assert property (
        1'b1 |=> hib_clk_en_o == $past(active[HIB_BIT]))
        else $error("hibernate enable does not follow selection");
    chk_rate_follow: assert property (
        1'b1 |=> converter_sample_rate_o == $past(active[RATE_HI:RATE_LO]))
        else $error("rate does not follow selection");
    chk_deep_ignored: assert property (
        !auto_gating_select || mode == MODE_RUN
        |=> wdt_clk_en_o == $past(run_gate_reg[WDT_BIT]))
        else $error("run enables not applied while running");
    chk_irq_level: assert property (
        irq_o == |(irq_stat & irq_mask))
        else $error("interrupt level wrong");
    chk_w1c_clear: assert property (
        wr_i && addr_i == IRQ_STAT_OFS
        |=> (irq_stat & $past(wdata_i[IRQ_W-1:0]) & ~$past(fault_evt)) == '0)
        else $error("status bit not cleared");
    chk_stat_hold: assert property (
        !(wr_i && addr_i == IRQ_STAT_OFS) |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
        else $error("status bit lost without clear");
    chk_stat_read: assert property (
        rd_i && addr_i == IRQ_STAT_OFS |=> rdata_o[IRQ_W-1:0] == $past(irq_stat))
        else $error("status read wrong");
    chk_mask_write: assert property (
        wr_i && addr_i == IRQ_MASK_OFS |=> irq_mask == $past(wdata_i[IRQ_W-1:0]))
        else $error("mask write lost");
    chk_rdata_idle: assert property (
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");
    chk_deep_hold: assert property (
        !(wr_i && addr_i == DEEP_GATE_OFS) |=> deep_gate_reg == $past(deep_gate_reg))
        else $error("deep gating changed without write");
    chk_sleep_write: assert property (
        wr_i && addr_i == SLEEP_GATE_OFS |=> sleep_gate_reg == ($past(wdata_i) & GATE_WMASK))
        else $error("sleep gating write lost");
    chk_run_write: assert property (
        wr_i && addr_i == RUN_GATE_OFS |=> run_gate_reg == ($past(wdata_i) & GATE_WMASK))
        else $error("run gating write lost");
    chk_sleep_reserved: assert property (
        (sleep_gate_reg & ~GATE_WMASK) == 32'h0000_0000)
        else $error("sleep reserved bit set");
    chk_cfg_reserved: assert property (
        (run_clock_config & ~CFG_WMASK) == 32'h0000_0000)
        else $error("configuration reserved bit set");
    chk_mode_deep: assert property (
        wr_i && addr_i == MODE_OFS && wdata_i[1:0] == MODE_CODE_DEEP |=> mode == MODE_DEEP)
        else $error("deep mode not entered");

    cov_deep_fault: cover property (mode == MODE_DEEP && auto_gating_select && per_fault_o);
    cov_w1c_clear: cover property (wr_i && addr_i == IRQ_STAT_OFS && irq_stat != '0);
    cov_sleep_mode: cover property (mode == MODE_SLEEP && auto_gating_select);
    cov_irq: cover property (irq_o);
    cov_rate_500k: cover property (converter_sample_rate_o == RATE_500K);

endmodule // deep_sleep_clock_gating
`default_nettype wire

/* deep_sleep_clock_gating_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module deep_sleep_clock_gating_tb
    import dsgate_pkg::*;
;
    logic mclk_i, rst_b_i, wr_i, rd_i, per_sel_adc_i, per_sel_wdt_i, per_sel_hib_i;
    logic [11:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rd_val;
    logic per_fault_o, adc_clk_en_o, hib_clk_en_o, wdt_clk_en_o, irq_o, fault_val;
    logic [1:0] converter_sample_rate_o;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;

    deep_sleep_clock_gating u_deep_sleep_clock_gating (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .per_sel_adc_i(per_sel_adc_i),
        .per_sel_wdt_i(per_sel_wdt_i), .per_sel_hib_i(per_sel_hib_i),
        .per_fault_o(per_fault_o), .adc_clk_en_o(adc_clk_en_o),
        .hib_clk_en_o(hib_clk_en_o), .wdt_clk_en_o(wdt_clk_en_o),
        .converter_sample_rate_o(converter_sample_rate_o), .irq_o(irq_o)
    );

    // ------------------------------------------------------------
    // Clock, timeout and closing report
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Guards against a hang; the sequence needs about a hundred cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rd_val = rdata_o;
    endtask

    // Access pulse to one unit: 0 converter, 1 watchdog, 2 hibernate
    task automatic access(input int unit);
        @(posedge mclk_i);
        per_sel_adc_i <= (unit == 0);
        per_sel_wdt_i <= (unit == 1);
        per_sel_hib_i <= (unit == 2);
        @(posedge mclk_i);
        {per_sel_adc_i, per_sel_wdt_i, per_sel_hib_i} <= 3'h0;
        #1 fault_val = per_fault_o;
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    task automatic chk_en(input logic a, input logic w, input logic h, input logic [1:0] r);
        `CHK(adc_clk_en_o, a)
        `CHK(wdt_clk_en_o, w)
        `CHK(hib_clk_en_o, h)
        `CHK(converter_sample_rate_o, r)
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0;
        {wr_i, rd_i, per_sel_adc_i, per_sel_wdt_i, per_sel_hib_i} = 5'h00;
        addr_i = 12'h000;
        wdata_i = 32'h0000_0000;
        repeat (3) @(posedge mclk_i);
        rst_b_i <= 1'b1;

        rd(DEEP_GATE_OFS); `CHK(rd_val, 32'h0000_0040)
        @(posedge mclk_i); #1 `CHK(rdata_o, 32'h0000_0000)
        rd(SLEEP_GATE_OFS); `CHK(rd_val, 32'h0000_0040)
        rd(RUN_GATE_OFS); `CHK(rd_val, 32'h0000_0040)
        rd(CLK_CFG_OFS); `CHK(rd_val, 32'h0000_0000)
        settle(); chk_en(1'b0, 1'b0, 1'b1, 2'h0);
        `CHK(irq_o, 1'b0)
        $display("test reset done");

        wr(DEEP_GATE_OFS, 32'hFFFF_FFFF);
        rd(DEEP_GATE_OFS); `CHK(rd_val, 32'h0001_0348)
        wr(DEEP_GATE_OFS, 32'h0000_0000);
        rd(DEEP_GATE_OFS); `CHK(rd_val, 32'h0000_0000)
        wr(DEEP_GATE_OFS, rd_val | 32'h0000_0040);
        rd(DEEP_GATE_OFS); `CHK(rd_val, 32'h0000_0040)
        wr(12'h0FC, 32'hFFFF_FFFF);
        rd(12'h0FC); `CHK(rd_val, 32'h0000_0000)
        $display("test register access done");

        wr(CLK_CFG_OFS, 32'h0800_0000);
        rd(CLK_CFG_OFS); `CHK(rd_val, 32'h0800_0000)
        wr(MODE_OFS, 32'h0000_0002);
        rd(MODE_OFS); `CHK(rd_val, 32'h0000_0002)
        for (int r = 0; r < 3; r++) begin
            wr(DEEP_GATE_OFS, 32'h0001_0008 | (r << 8));
            settle(); chk_en(1'b1, 1'b1, 1'b0, r[1:0]);
        end
        $display("test deep sleep done");

        wr(SLEEP_GATE_OFS, 32'h0000_0108);
        wr(MODE_OFS, 32'h0000_0001);
        settle(); chk_en(1'b0, 1'b1, 1'b0, 2'h1);
        rd(MODE_OFS); `CHK(rd_val, 32'h0000_0001)
        wr(MODE_OFS, 32'h0000_0000);
        settle(); chk_en(1'b0, 1'b0, 1'b1, 2'h0);
        rd(MODE_OFS); `CHK(rd_val, 32'h0000_0000)
        wr(MODE_OFS, 32'h0000_0001);
        wr(CLK_CFG_OFS, 32'h0000_0000);
        settle(); chk_en(1'b0, 1'b0, 1'b1, 2'h0);
        $display("test mode select done");

        wr(IRQ_MASK_OFS, 32'h0000_0007);
        access(1); `CHK(fault_val, 1'b1)
        @(posedge mclk_i); #1 `CHK(irq_o, 1'b1)
        `CHK(per_fault_o, 1'b0)
        access(2); `CHK(fault_val, 1'b0)
        access(0); `CHK(fault_val, 1'b1)
        rd(IRQ_STAT_OFS); `CHK(rd_val, 32'h0000_0003)
        wr(IRQ_STAT_OFS, 32'h0000_0003);
        settle(); `CHK(irq_o, 1'b0)
        wr(RUN_GATE_OFS, 32'h0001_0000);
        settle(); access(0); `CHK(fault_val, 1'b0)
        access(2); `CHK(fault_val, 1'b1)
        wr(IRQ_MASK_OFS, 32'h0000_0000);
        settle(); `CHK(irq_o, 1'b0)
        rd(IRQ_STAT_OFS); `CHK(rd_val, 32'h0000_0004)
        $display("test bus fault done");

        tally_and_finish();
    end
endmodule // deep_sleep_clock_gating_tb
`default_nettype wire
